// [sct_defines.svh]
`ifndef SCT_DEFINES_SVH
`define SCT_DEFINES_SVH

// register indices; byte address is four times the index
`define SCT_IDX_PORT1_CFG 8'hc1
`define SCT_IDX_TIMING 8'hc7
`define SCT_IDX_IRQ_STATUS 8'hd0
`define SCT_IDX_IRQ_MASK 8'hd1

// reset values
`define SCT_RST_PORT1_CFG 8'h00
`define SCT_RST_TIMING 8'h00
`define SCT_RST_IRQ 4'h0

// port1 configuration fields
`define SCT_CFG_ENABLE 7
`define SCT_CFG_INHIBIT 6
`define SCT_CFG_BUSY 5
`define SCT_CFG_EXTHOLD 4
`define SCT_CFG_LOW_TO 3
`define SCT_CFG_FREE_TO 2
`define SCT_CFG_SRC_HI 1
`define SCT_CFG_SRC_LO 0

// timing and pin control fields
`define SCT_TC_P1_SWAP 7
`define SCT_TC_P0_SWAP 6
`define SCT_TC_P1_WIN_HI 3
`define SCT_TC_P1_WIN_LO 2
`define SCT_TC_P0_WIN_HI 1
`define SCT_TC_P0_WIN_LO 0

// interrupt status bits
`define SCT_IRQ_P1_START 0
`define SCT_IRQ_P1_STOP 1
`define SCT_IRQ_P1_FREE 2
`define SCT_IRQ_P0_START 3

// timing counts in system clocks / bit-rate periods
`define SCT_HOLD_BASE 4'h1
`define SCT_HOLD_EXTRA_W1 4'h2
`define SCT_HOLD_EXTRA_W2 4'h4
`define SCT_HOLD_EXTRA_W3 4'h8
`define SCT_FREE_PERIODS 10

// axi responses
`define SCT_RESP_OKAY 2'b00
`define SCT_RESP_SLVERR 2'b10

`endif

// [sct_pkg.sv]
`include "sct_defines.svh"

package sct_pkg;

	// one-cycle line events from a start detector
	typedef struct packed {
		logic start;
		logic stop;
	} sct_line_event_s;

	// start detector state
	typedef struct packed {
		logic prev_data;
		logic prev_clock;
		logic armed;
		logic [3:0] count;
		sct_line_event_s evt;
	} sct_detect_s;

	// main block state
	typedef struct packed {
		logic [7:0] cfg;
		logic busy;
		logic [7:0] timing;
		logic [3:0] irq_status;
		logic [3:0] irq_mask;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] free_count;
		logic bitrate_tick;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} sct_state_s;

	// least data-fall to clock-fall hold, in system clocks, per window code
	function automatic logic [3:0] hold_min(input logic [1:0] win);
		case (win)
			2'b01: hold_min = `SCT_HOLD_BASE + `SCT_HOLD_EXTRA_W1;
			2'b10: hold_min = `SCT_HOLD_BASE + `SCT_HOLD_EXTRA_W2;
			2'b11: hold_min = `SCT_HOLD_BASE + `SCT_HOLD_EXTRA_W3;
			default: hold_min = `SCT_HOLD_BASE;
		endcase
	endfunction : hold_min

endpackage : sct_pkg

// [sct_start_detect.sv]
`timescale 1ns/1ps
`default_nettype none

module sct_start_detect (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	// control
	input wire logic i_enable,
	input wire logic [1:0] i_window,
	// synchronised lines
	input wire logic i_data,
	input wire logic i_clock_line,
	// events
	output sct_pkg::sct_line_event_s o_event
);

	sct_pkg::sct_detect_s q;
	sct_pkg::sct_detect_s next_q;
	logic [3:0] need;

	assign need = sct_pkg::hold_min(i_window);
	assign o_event = q.evt;

	// edge tracking and hold counting
	always_comb begin
		next_q = q;
		next_q.evt = '0;
		next_q.prev_data = i_data;
		next_q.prev_clock = i_clock_line;
		if (!i_enable) begin
			next_q.armed = 1'b0;
			next_q.count = 4'h0;
		end else if (q.prev_data && !i_data && i_clock_line) begin
			next_q.armed = 1'b1;
			next_q.count = 4'h0;
		end else if (!q.prev_data && i_data && i_clock_line) begin
			next_q.armed = 1'b0;
			next_q.evt.stop = 1'b1;
		end else if (q.armed) begin
			if (q.prev_clock && !i_clock_line) begin
				// elapsed = count + 1; tested as count >= need - 1 so a
				// saturated count cannot wrap; need is at least 1
				next_q.evt.start = (q.count >= need - 4'h1);
				next_q.armed = 1'b0;
			end else if (q.count != 4'hf) begin
				next_q.count = q.count + 4'h1;
			end
		end
	end

	// state register
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			q <= '0;
			// idle bus is high; a zero here would fake a stop after reset
			q.prev_data <= 1'b1;
			q.prev_clock <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

endmodule : sct_start_detect

`default_nettype wire

// [sct_config_timing.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sct_defines.svh"

// Operation
// - enable bit activates port1 and makes it watch its data and clock lines
// - slave inhibit blocks slave interrupts; master interrupts still pass
// - busy set while a transfer runs, cleared by stop or bus-free timeout
// - extend bit picks normal (0) or extended (1) setup and hold timing
// - clock-low timeout: timer reloads while clock high, counts while low
// - split-mode timer: only its high byte reloads while clock high
// - bus free once clock and data high more than 10 source periods
// - source field: timer0, timer5, timer2 high byte, timer2 low byte
// - port1 swap: data low pin and clock high pin, reversed when 1
// - port0 swap: data low pin and clock high pin, reversed when 1
// - start window lengthens needed data-fall to clock-fall hold time
// - port1 window codes give 0-1, 2-3, 4-5, 8-9 system clocks
// - port0 window uses the same encoding as port1
// - default window: clock fall one clock after data fall is start
module sct_config_timing #(
	parameter int FREE_PERIODS = `SCT_FREE_PERIODS
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	// axi4-lite write address
	input wire logic i_axi_awvalid,
	output logic o_axi_awready,
	input wire logic [11:0] i_axi_awaddr,
	// axi4-lite write data
	input wire logic i_axi_wvalid,
	output logic o_axi_wready,
	input wire logic [31:0] i_axi_wdata,
	input wire logic [3:0] i_axi_wstrb,
	// axi4-lite write response
	output logic o_axi_bvalid,
	input wire logic i_axi_bready,
	output logic [1:0] o_axi_bresp,
	// axi4-lite read address
	input wire logic i_axi_arvalid,
	output logic o_axi_arready,
	input wire logic [11:0] i_axi_araddr,
	// axi4-lite read data
	output logic o_axi_rvalid,
	input wire logic i_axi_rready,
	output logic [31:0] o_axi_rdata,
	output logic [1:0] o_axi_rresp,
	// interrupt
	output logic o_irq,
	// port0 crossbar pins, open drain
	input wire logic i_port0_pin_lo,
	output logic o_port0_pin_lo,
	output logic o_port0_pin_lo_oe_n,
	input wire logic i_port0_pin_hi,
	output logic o_port0_pin_hi,
	output logic o_port0_pin_hi_oe_n,
	// port1 crossbar pins, open drain
	input wire logic i_port1_pin_lo,
	output logic o_port1_pin_lo,
	output logic o_port1_pin_lo_oe_n,
	input wire logic i_port1_pin_hi,
	output logic o_port1_pin_hi,
	output logic o_port1_pin_hi_oe_n,
	// port0 engine side
	input wire logic i_port0_enable,
	input wire logic i_port0_data_pull_low,
	input wire logic i_port0_clock_pull_low,
	output sct_pkg::sct_line_event_s o_port0_event,
	// port1 engine side
	input wire logic i_port1_data_pull_low,
	input wire logic i_port1_clock_pull_low,
	input wire logic i_port1_slave_event,
	input wire logic i_port1_master_event,
	output logic o_port1_enable,
	output logic o_port1_extended_hold,
	output logic o_port1_busy,
	output logic o_port1_bitrate_tick,
	output logic o_port1_slave_irq,
	output logic o_port1_master_irq,
	output sct_pkg::sct_line_event_s o_port1_event,
	// bit-rate overflow sources: t0, t5, t2 high, t2 low
	input wire logic [3:0] i_overflow,
	// clock-low timeout timer control
	input wire logic i_timer_split,
	output logic o_timer_reload_high,
	output logic o_timer_reload_low,
	output logic o_timer_count
);

	// free count must reach FREE_PERIODS + 1 within four bits
	if (FREE_PERIODS < 1 || FREE_PERIODS > 14) begin : g_check
		$error("FREE_PERIODS must lie in 1..14");
	end

	localparam logic [3:0] FREE_LIMIT = 4'(FREE_PERIODS);

	sct_pkg::sct_state_s q;
	sct_pkg::sct_state_s next_q;

	logic p0_data;
	logic p0_clock;
	logic p1_data;
	logic p1_clock;
	logic p1_en;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic wr_ok;
	logic rd_ok;
	logic [3:0] events;
	logic [3:0] w1c;
	logic free_evt;
	logic [7:0] cfg_view;
	sct_pkg::sct_line_event_s p0_evt;
	sct_pkg::sct_line_event_s p1_evt;

	// register index from a byte address; valid only if word aligned
	function automatic logic [7:0] reg_index(input logic [11:0] addr);
		reg_index = addr[9:2];
	endfunction : reg_index

	function automatic logic reg_mapped(input logic [11:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		reg_mapped = (addr[1:0] == 2'b00) && (addr[11:10] == 2'b00) &&
			(idx == `SCT_IDX_PORT1_CFG || idx == `SCT_IDX_TIMING ||
			idx == `SCT_IDX_IRQ_STATUS || idx == `SCT_IDX_IRQ_MASK);
	endfunction : reg_mapped

	// pin order through the crossbar
	assign p0_data = q.timing[`SCT_TC_P0_SWAP] ? q.sync2[1] : q.sync2[0];
	assign p0_clock = q.timing[`SCT_TC_P0_SWAP] ? q.sync2[0] : q.sync2[1];
	assign p1_data = q.timing[`SCT_TC_P1_SWAP] ? q.sync2[3] : q.sync2[2];
	assign p1_clock = q.timing[`SCT_TC_P1_SWAP] ? q.sync2[2] : q.sync2[3];
	assign p1_en = q.cfg[`SCT_CFG_ENABLE];

	// pin drivers: always drive low, enable low means driving
	assign o_port0_pin_lo = 1'b0;
	assign o_port0_pin_hi = 1'b0;
	assign o_port1_pin_lo = 1'b0;
	assign o_port1_pin_hi = 1'b0;
	assign o_port0_pin_lo_oe_n = !(i_port0_enable && (q.timing[`SCT_TC_P0_SWAP] ?
		i_port0_clock_pull_low : i_port0_data_pull_low));
	assign o_port0_pin_hi_oe_n = !(i_port0_enable && (q.timing[`SCT_TC_P0_SWAP] ?
		i_port0_data_pull_low : i_port0_clock_pull_low));
	assign o_port1_pin_lo_oe_n = !(p1_en && (q.timing[`SCT_TC_P1_SWAP] ?
		i_port1_clock_pull_low : i_port1_data_pull_low));
	assign o_port1_pin_hi_oe_n = !(p1_en && (q.timing[`SCT_TC_P1_SWAP] ?
		i_port1_data_pull_low : i_port1_clock_pull_low));

	// start and stop detection, one per port
	sct_start_detect u_detect0 (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_enable(i_port0_enable),
		.i_window(q.timing[`SCT_TC_P0_WIN_HI:`SCT_TC_P0_WIN_LO]),
		.i_data(p0_data),
		.i_clock_line(p0_clock),
		.o_event(p0_evt)
	);

	sct_start_detect u_detect1 (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_enable(p1_en),
		.i_window(q.timing[`SCT_TC_P1_WIN_HI:`SCT_TC_P1_WIN_LO]),
		.i_data(p1_data),
		.i_clock_line(p1_clock),
		.o_event(p1_evt)
	);

	assign o_port0_event = p0_evt;
	assign o_port1_event = p1_evt;

	// port1 status and steering outputs
	assign o_port1_enable = p1_en;
	assign o_port1_extended_hold = q.cfg[`SCT_CFG_EXTHOLD];
	assign o_port1_busy = q.busy;
	assign o_port1_bitrate_tick = q.bitrate_tick;

	// slave events vanish under inhibit; master events pass whenever port1 is enabled
	assign o_port1_slave_irq = p1_en && i_port1_slave_event &&
		!q.cfg[`SCT_CFG_INHIBIT];
	assign o_port1_master_irq = p1_en && i_port1_master_event;

	// clock-low timeout timer: reload while high, count while low
	assign o_timer_reload_high = p1_en && q.cfg[`SCT_CFG_LOW_TO] &&
		p1_clock;
	assign o_timer_reload_low = p1_en && q.cfg[`SCT_CFG_LOW_TO] &&
		p1_clock && !i_timer_split;
	assign o_timer_count = p1_en && q.cfg[`SCT_CFG_LOW_TO] && !p1_clock;

	// free timeout fires on the period after the tenth full one
	assign free_evt = p1_en && q.cfg[`SCT_CFG_FREE_TO] && p1_data &&
		p1_clock && q.bitrate_tick && (q.free_count == FREE_LIMIT);

	// sticky interrupt sources
	always_comb begin
		events = 4'h0;
		events[`SCT_IRQ_P1_START] = p1_evt.start;
		events[`SCT_IRQ_P1_STOP] = p1_evt.stop;
		events[`SCT_IRQ_P1_FREE] = free_evt;
		events[`SCT_IRQ_P0_START] = p0_evt.start;
	end

	// axi handshakes: address and data are taken together
	assign wr_fire = i_axi_awvalid && i_axi_wvalid && !q.bvalid;
	assign rd_fire = i_axi_arvalid && !q.rvalid;
	assign o_axi_awready = wr_fire;
	assign o_axi_wready = wr_fire;
	assign o_axi_arready = rd_fire;
	assign o_axi_bvalid = q.bvalid;
	assign o_axi_bresp = q.bresp;
	assign o_axi_rvalid = q.rvalid;
	assign o_axi_rresp = q.rresp;
	assign o_axi_rdata = q.rdata;
	assign o_irq = |(q.irq_status & q.irq_mask);

	assign wr_idx = reg_index(i_axi_awaddr);
	assign rd_idx = reg_index(i_axi_araddr);
	assign wr_ok = reg_mapped(i_axi_awaddr);
	assign rd_ok = reg_mapped(i_axi_araddr);
	assign w1c = (wr_fire && wr_ok && i_axi_wstrb[0] &&
		wr_idx == `SCT_IDX_IRQ_STATUS) ? i_axi_wdata[3:0] : 4'h0;

	// busy reads back live; its stored bit is always written as zero
	always_comb begin
		cfg_view = q.cfg;
		cfg_view[`SCT_CFG_BUSY] = q.busy;
	end

	// next state
	always_comb begin
		next_q = q;
		// two flip-flops on every pin before use
		next_q.sync1 = {i_port1_pin_hi, i_port1_pin_lo,
			i_port0_pin_hi, i_port0_pin_lo};
		next_q.sync2 = q.sync1;

		// selected overflow becomes the bit-rate tick
		next_q.bitrate_tick = p1_en &&
			i_overflow[q.cfg[`SCT_CFG_SRC_HI:`SCT_CFG_SRC_LO]];

		// idle-high period counter, restarts when either line drops
		if (!(p1_en && q.cfg[`SCT_CFG_FREE_TO] && p1_data && p1_clock)) begin
			next_q.free_count = 4'h0;
		end else if (q.bitrate_tick && q.free_count != FREE_LIMIT + 4'h1) begin
			next_q.free_count = q.free_count + 4'h1;
		end

		// busy: a start sets it, stop or free timeout clears it
		if (!p1_en) begin
			next_q.busy = 1'b0;
		end else if (p1_evt.start) begin
			next_q.busy = 1'b1;
		end else if (p1_evt.stop || free_evt) begin
			next_q.busy = 1'b0;
		end

		// set wins over a write-one clear in the same cycle
		next_q.irq_status = (q.irq_status & ~w1c) | events;

		// write channel
		if (q.bvalid && i_axi_bready) begin
			next_q.bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_q.bvalid = 1'b1;
			next_q.bresp = wr_ok ? `SCT_RESP_OKAY : `SCT_RESP_SLVERR;
			if (wr_ok && i_axi_wstrb[0]) begin
				case (wr_idx)
					`SCT_IDX_PORT1_CFG: begin
						next_q.cfg = i_axi_wdata[7:0];
						next_q.cfg[`SCT_CFG_BUSY] = 1'b0;
						// disabling drops busy on the same edge
						if (!i_axi_wdata[`SCT_CFG_ENABLE]) begin
							next_q.busy = 1'b0;
						end
					end
					`SCT_IDX_TIMING: begin
						next_q.timing = i_axi_wdata[7:0];
					end
					`SCT_IDX_IRQ_MASK: begin
						next_q.irq_mask = i_axi_wdata[3:0];
					end
					default: begin
						next_q.cfg = q.cfg;
					end
				endcase
			end
		end

		// read channel
		if (q.rvalid && i_axi_rready) begin
			next_q.rvalid = 1'b0;
		end
		if (rd_fire) begin
			next_q.rvalid = 1'b1;
			next_q.rresp = rd_ok ? `SCT_RESP_OKAY : `SCT_RESP_SLVERR;
			next_q.rdata = 32'h0000_0000;
			if (rd_ok) begin
				case (rd_idx)
					`SCT_IDX_PORT1_CFG: begin
						next_q.rdata[7:0] = cfg_view;
					end
					`SCT_IDX_TIMING: begin
						next_q.rdata[7:0] = q.timing;
					end
					`SCT_IDX_IRQ_STATUS: begin
						next_q.rdata[3:0] = q.irq_status;
					end
					`SCT_IDX_IRQ_MASK: begin
						next_q.rdata[3:0] = q.irq_mask;
					end
					default: begin
						next_q.rdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// state register; everything clears to zero except the pin synchronisers, which load all ones
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			q <= '0;
			q.cfg <= `SCT_RST_PORT1_CFG;
			q.timing <= `SCT_RST_TIMING;
			q.irq_status <= `SCT_RST_IRQ;
			q.irq_mask <= `SCT_RST_IRQ;
			q.sync1 <= 4'hf;
			q.sync2 <= 4'hf;
		end else begin
			q <= next_q;
		end
	end

endmodule : sct_config_timing

`default_nettype wire

// [sct_config_timing_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module sct_config_timing_checker (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	// bus handshakes
	input wire logic i_axi_awvalid,
	input wire logic o_axi_awready,
	input wire logic o_axi_bvalid,
	input wire logic i_axi_arvalid,
	input wire logic o_axi_arready,
	input wire logic o_axi_rvalid,
	// port1 engine side
	input wire logic o_port1_enable,
	input wire logic o_port1_busy,
	input wire logic i_port1_slave_event,
	input wire logic i_port1_master_event,
	input wire logic o_port1_slave_irq,
	input wire logic o_port1_master_irq,
	input wire sct_pkg::sct_line_event_s o_port1_event,
	input wire logic [3:0] i_overflow,
	input wire logic o_port1_bitrate_tick,
	// timeout timer
	input wire logic i_timer_split,
	input wire logic o_timer_reload_high,
	input wire logic o_timer_reload_low,
	input wire logic o_timer_count
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);

	// a handshake is answered on the very next edge
	sequence s_aw; i_axi_awvalid && o_axi_awready; endsequence
	sequence s_ar; i_axi_arvalid && o_axi_arready; endsequence
	property p_wr; s_aw |=> o_axi_bvalid; endproperty
	property p_rd; s_ar |=> o_axi_rvalid; endproperty
	property p_mirq;
		o_port1_master_irq == (i_port1_master_event && o_port1_enable);
	endproperty
	property p_sirq;
		o_port1_slave_irq |-> i_port1_slave_event && o_port1_enable;
	endproperty
	property p_idle; !o_port1_enable |-> !o_port1_busy; endproperty
	property p_set; o_port1_event.start |=> o_port1_busy; endproperty
	property p_clr; o_port1_event.stop |=> !o_port1_busy; endproperty
	property p_rld; o_timer_count |-> !o_timer_reload_high; endproperty
	property p_split;
		i_timer_split && o_timer_reload_high |-> !o_timer_reload_low;
	endproperty
	property p_tick; o_port1_bitrate_tick |-> $past(i_overflow) != 4'h0;
	endproperty
	property p_pulse; o_port1_event.start |=> !o_port1_event.start;
	endproperty

	a_wr: assert property (p_wr) else $error("write not answered");
	a_rd: assert property (p_rd) else $error("read not answered");
	a_mirq: assert property (p_mirq) else $error("master irq wrong");
	a_sirq: assert property (p_sirq) else $error("slave irq wrong");
	a_idle: assert property (p_idle) else $error("busy while off");
	a_set: assert property (p_set) else $error("busy not set");
	a_clr: assert property (p_clr) else $error("busy not cleared");
	a_rld: assert property (p_rld) else $error("reload and count");
	a_split: assert property (p_split) else $error("low byte reload");
	a_tick: assert property (p_tick) else $error("tick without source");
	a_pulse: assert property (p_pulse) else $error("start too long");
endmodule : sct_config_timing_checker

bind sct_config_timing sct_config_timing_checker u_chk (.i_clock, .i_srst,
	.i_axi_awvalid, .o_axi_awready, .o_axi_bvalid, .i_axi_arvalid,
	.o_axi_arready, .o_axi_rvalid, .o_port1_enable, .o_port1_busy,
	.i_port1_slave_event, .i_port1_master_event, .o_port1_slave_irq,
	.o_port1_master_irq, .o_port1_event, .i_overflow, .o_port1_bitrate_tick,
	.i_timer_split, .o_timer_reload_high, .o_timer_reload_low, .o_timer_count);

`default_nettype wire

// [sct_bus_peer.sv]
`timescale 1ns/1ps
`default_nettype none

module sct_bus_peer (
	// clock
	input wire logic i_clock,
	// pin map and design drive
	input wire logic i_swap,
	input wire logic i_oe_lo_n,
	input wire logic i_oe_hi_n,
	// resolved pins
	output logic o_pin_lo,
	output logic o_pin_hi
);
	logic data_low = 1'b0;
	logic clock_low = 1'b0;

	// pull-ups win unless a party pulls; swap picks each pin's role
	assign o_pin_lo = i_oe_lo_n && !(i_swap ? clock_low : data_low);
	assign o_pin_hi = i_oe_hi_n && !(i_swap ? data_low : clock_low);

	// data falls, clock follows gap clocks later
	task automatic start_seq(input int gap);
		@(posedge i_clock);
		data_low <= 1'b1;
		repeat (gap) @(posedge i_clock);
		clock_low <= 1'b1;
		repeat (6) @(posedge i_clock);
	endtask : start_seq

	// clock released first, then data rises while clock high
	task automatic stop_seq();
		@(posedge i_clock);
		clock_low <= 1'b0;
		repeat (3) @(posedge i_clock);
		data_low <= 1'b0;
		repeat (6) @(posedge i_clock);
	endtask : stop_seq
endmodule : sct_bus_peer

`default_nettype wire

// [tb_smbus_config_timing.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sct_defines.svh"

module tb_smbus_config_timing;
	localparam logic [11:0] A_CFG = {2'b00, `SCT_IDX_PORT1_CFG, 2'b00};
	localparam logic [11:0] A_TC = {2'b00, `SCT_IDX_TIMING, 2'b00};
	localparam logic [11:0] A_ST = {2'b00, `SCT_IDX_IRQ_STATUS, 2'b00};
	localparam logic [11:0] A_MK = {2'b00, `SCT_IDX_IRQ_MASK, 2'b00};
	logic i_clock = 1'b0, i_srst = 1'b1;
	logic i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
	logic i_axi_arvalid = 1'b0, i_axi_rready = 1'b0, i_timer_split = 1'b0;
	logic [11:0] i_axi_awaddr = 12'h000, i_axi_araddr = 12'h000;
	logic [31:0] i_axi_wdata = 32'h0, o_axi_rdata, rdat;
	logic [3:0] i_axi_wstrb = 4'hf, i_overflow = 4'h0;
	logic i_port0_enable = 1'b1, i_port0_data_pull_low = 1'b0;
	logic i_port1_data_pull_low = 1'b0, i_port0_clock_pull_low = 1'b0;
	logic i_port1_clock_pull_low = 1'b0, i_port1_slave_event = 1'b0;
	logic i_port1_master_event = 1'b0, o_axi_bvalid, o_axi_rvalid, o_irq;
	logic o_axi_awready, o_axi_arready, o_port1_busy, o_port1_bitrate_tick;
	logic o_port0_pin_lo_oe_n, o_port0_pin_hi_oe_n, o_port1_pin_lo_oe_n;
	logic o_port1_pin_hi_oe_n, o_port1_enable, o_port1_extended_hold;
	logic o_port1_slave_irq, o_port1_master_irq, o_timer_reload_high;
	logic o_timer_reload_low, o_timer_count, o_axi_wready;
	logic [1:0] o_axi_bresp, o_axi_rresp, resp;
	logic [7:0] tc = 8'h00;
	wire p0_lo, p0_hi, p1_lo, p1_hi;
	sct_pkg::sct_line_event_s o_port0_event, o_port1_event;
	int n_fail = 0, n_checks = 0;

	always #2.5 i_clock = ~i_clock;

	sct_config_timing #(.FREE_PERIODS(2)) u_dut (.i_clock, .i_srst,
		.i_axi_awvalid, .o_axi_awready, .i_axi_awaddr, .i_axi_wvalid,
		.o_axi_wready, .i_axi_wdata, .i_axi_wstrb, .o_axi_bvalid,
		.i_axi_bready, .o_axi_bresp, .i_axi_arvalid, .o_axi_arready,
		.i_axi_araddr, .o_axi_rvalid, .i_axi_rready, .o_axi_rdata,
		.o_axi_rresp, .o_irq, .i_port0_pin_lo(p0_lo), .o_port0_pin_lo(),
		.o_port0_pin_lo_oe_n, .i_port0_pin_hi(p0_hi), .o_port0_pin_hi(),
		.o_port0_pin_hi_oe_n, .i_port1_pin_lo(p1_lo), .o_port1_pin_lo(),
		.o_port1_pin_lo_oe_n, .i_port1_pin_hi(p1_hi), .o_port1_pin_hi(),
		.o_port1_pin_hi_oe_n, .i_port0_enable, .i_port0_data_pull_low,
		.i_port0_clock_pull_low, .o_port0_event, .i_port1_data_pull_low,
		.i_port1_clock_pull_low, .i_port1_slave_event, .i_port1_master_event,
		.o_port1_enable, .o_port1_extended_hold, .o_port1_busy,
		.o_port1_bitrate_tick, .o_port1_slave_irq, .o_port1_master_irq,
		.o_port1_event, .i_overflow, .i_timer_split, .o_timer_reload_high,
		.o_timer_reload_low, .o_timer_count);
	sct_bus_peer u_p0 (.i_clock, .i_swap(tc[6]), .i_oe_lo_n(o_port0_pin_lo_oe_n),
		.i_oe_hi_n(o_port0_pin_hi_oe_n), .o_pin_lo(p0_lo), .o_pin_hi(p0_hi));
	sct_bus_peer u_p1 (.i_clock, .i_swap(tc[7]), .i_oe_lo_n(o_port1_pin_lo_oe_n),
		.i_oe_hi_n(o_port1_pin_hi_oe_n), .o_pin_lo(p1_lo), .o_pin_hi(p1_hi));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// bounded wait on awready, bvalid, arready or rvalid
	task automatic wt(input int sel);
		int k;
		logic [3:0] v;
		for (k = 0; k < 40; k++) begin
			@(posedge i_clock);
			v = {o_axi_rvalid, o_axi_arready, o_axi_bvalid, o_axi_awready};
			if (v[sel] === 1'b1) break;
		end
		if (k == 40) begin
			n_fail++;
			wrap_up();
		end
	endtask : wt

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		i_axi_awaddr <= a;
		i_axi_wdata <= {24'h0, d};
		{i_axi_awvalid, i_axi_wvalid, i_axi_bready} <= 3'b111;
		wt(0);
		chk("wready", o_axi_wready, 1);
		{i_axi_awvalid, i_axi_wvalid} <= 2'b00;
		wt(1);
		// bready stays up: a back-to-back write must not re-raise it
		resp = o_axi_bresp;
	endtask : wr

	task automatic rd(input logic [11:0] a);
		i_axi_araddr <= a;
		{i_axi_arvalid, i_axi_rready} <= 2'b11;
		wt(2);
		i_axi_arvalid <= 1'b0;
		wt(3);
		// rready stays up for the same reason as bready
		{rdat, resp} = {o_axi_rdata, o_axi_rresp};
	endtask : rd

	task automatic t_regs();
		rd(A_CFG);
		chk("cfg reset", rdat, 0);
		rd(A_TC);
		chk("timing reset", rdat, 0);
		rd(12'h008);
		chk("unmapped read", resp, `SCT_RESP_SLVERR);
		wr(A_CFG, 8'hb0);
		rd(A_CFG);
		chk("busy read only", rdat, 32'h90);
		chk("enable out", o_port1_enable, 1);
		chk("extend on", o_port1_extended_hold, 1);
		wr(A_CFG, 8'h80);
		chk("extend off", o_port1_extended_hold, 0);
	endtask : t_regs

	task automatic t_swap();
		for (int s = 0; s < 2; s++) begin
			tc = {s[0], s[0], 6'h0};
			wr(A_TC, tc);
			{i_port1_data_pull_low, i_port0_data_pull_low} <= 2'b11;
			@(negedge i_clock);
			chk("p1 lo drive", o_port1_pin_lo_oe_n, s);
			chk("p1 hi drive", o_port1_pin_hi_oe_n, !s);
			chk("p0 lo drive", o_port0_pin_lo_oe_n, s);
			chk("p0 hi drive", o_port0_pin_hi_oe_n, !s);
			@(posedge i_clock);
			{i_port1_data_pull_low, i_port0_data_pull_low} <= 2'b00;
		end
	endtask : t_swap

	// start with a given gap on one port, then stop
	task automatic go(input int p, g, input logic exp);
		logic [31:0] m;
		m = p ? 32'h1 : 32'h8;
		wr(A_ST, 8'h0f);
		if (p) u_p1.start_seq(g);
		else u_p0.start_seq(g);
		rd(A_ST);
		chk("start seen", rdat & m, exp ? m : 0);
		if (p) chk("busy", o_port1_busy, exp);
		if (p) u_p1.stop_seq();
		else u_p0.stop_seq();
		chk("busy after stop", o_port1_busy, 0);
	endtask : go

	task automatic t_win(input int p);
		int n;
		for (int w = 0; w < 4; w++) begin
			n = (w == 0) ? 1 : (w == 1) ? 3 : (w == 2) ? 5 : 9;
			// idle port's field is the complement, so a field mix-up shows
			tc = {tc[7:6], 2'b00, p[0] ? w[1:0] : ~w[1:0],
				p[0] ? ~w[1:0] : w[1:0]};
			wr(A_TC, tc);
			if (w > 0) go(p, n - 1, 1'b0);
			go(p, n, 1'b1);
		end
	endtask : t_win

	task automatic t_irq();
		tc = 8'h00;
		wr(A_TC, tc);
		go(1, 1, 1'b1);
		chk("irq masked", o_irq, 0);
		wr(A_MK, 8'h01);
		chk("irq raised", o_irq, 1);
		wr(A_ST, 8'h01);
		chk("irq cleared", o_irq, 0);
		wr(A_MK, 8'h00);
	endtask : t_irq

	task automatic t_slave();
		for (int h = 0; h < 2; h++) begin
			wr(A_CFG, {1'b1, h[0], 6'h0});
			{i_port1_slave_event, i_port1_master_event} <= 2'b11;
			@(negedge i_clock);
			chk("slave irq", o_port1_slave_irq, !h);
			chk("master irq", o_port1_master_irq, 1);
			@(posedge i_clock);
			{i_port1_slave_event, i_port1_master_event} <= 2'b00;
		end
	endtask : t_slave

	task automatic t_timer();
		wr(A_CFG, 8'h88);
		i_timer_split <= 1'b1;
		repeat (4) @(negedge i_clock);
		chk("reload high", o_timer_reload_high, 1);
		chk("no count", o_timer_count, 0);
		chk("split low", o_timer_reload_low, 0);
		u_p1.start_seq(1); // held-low clock is what the timer counts
		chk("count low", o_timer_count, 1);
		i_timer_split <= 1'b0;
		u_p1.stop_seq();
		chk("full reload", o_timer_reload_low, 1);
	endtask : t_timer

	// only the selected source ticks; third tick frees the bus
	task automatic t_free();
		wr(A_ST, 8'h0f);
		for (int s = 0; s < 4; s++) begin
			wr(A_CFG, 8'h84 | s[7:0]);
			i_overflow <= ~(4'h1 << s);
			@(posedge i_clock);
			i_overflow <= 4'h1 << s;
			@(negedge i_clock);
			chk("other source", o_port1_bitrate_tick, 0);
			@(posedge i_clock);
			i_overflow <= 4'h0;
			@(negedge i_clock);
			chk("tick", o_port1_bitrate_tick, 1);
			repeat (3) @(posedge i_clock);
			rd(A_ST);
			chk("bus free", rdat & 4, s >= 2 ? 4 : 0);
		end
	endtask : t_free

	initial begin
		repeat (6) @(posedge i_clock);
		i_srst <= 1'b0;
		@(posedge i_clock);
		t_regs();
		t_swap();
		t_win(1);
		t_win(0);
		t_irq();
		t_slave();
		t_timer();
		t_free();
		wrap_up();
	end
endmodule : tb_smbus_config_timing

`default_nettype wire
